/* logic/fasc_cfg.svh */
// constants for the framer auxiliary status and control bank
// ---------------------------------------------------------------
// Contract
// R1 - deactivate flag with enable drives interrupt
// R2 - activate-present toggle sets activate flag
// R3 - deactivate-present toggle sets deactivate flag
// R4 - event flags clear on written one
// R5 - out of sync substitutes idle byte
// R6 - idle byte writable, resets to all ones
// R7 - slip direction: 0 empty, 1 full
// R8 - slip sets flag; enabled flag interrupts
// R9 - auto report once per second in ESF
// R10 - five software bits fill each report
// R11 - non all-ones code sent as message
// R12 - message is 11111110, code0..5, 0
// R13 - select 0: 8 of 10 identical, new
// R14 - select 1: 4 of 5 identical, new
// R15 - declared message loads code, sets flag
// R16 - message flag with enable drives interrupt
// R17 - transmitter two/three enables gate all functions; the code leaves the channel outputs ungated
// R18 - transmitter one enable only in ESF/DM
// R19 - even bit inserts into even frames
// R20 - odd bit inserts into odd frames
// R21 - channel field picks channel; ignored when unassigned
// R22 - interrupt is OR of enabled flags
// ---------------------------------------------------------------
`ifndef FASC_CFG_SVH
`define FASC_CFG_SVH

// register indices; byte address is four times the index
`define FASC_IDX_LOOP_EN    10'h07A
`define FASC_IDX_LOOP_FLAG  10'h07B
`define FASC_IDX_ES_CFG     10'h07C
`define FASC_IDX_SLIP_FLAG  10'h07D
`define FASC_IDX_IDLE_BYTE  10'h07E
`define FASC_IDX_REPORT     10'h07F
`define FASC_IDX_TX_CODE    10'h080
`define FASC_IDX_MSG_CTL    10'h081
`define FASC_IDX_MSG_FLAG   10'h082
`define FASC_IDX_RX_CODE    10'h083
`define FASC_IDX_HDLC_EN    10'h084
`define FASC_IDX_ASSIGN2    10'h086
`define FASC_IDX_ASSIGN3    10'h087

// field positions
`define FASC_B_ACT      1
`define FASC_B_DEACT    0
`define FASC_B_SUBST    2
`define FASC_B_SLIPDIR  1
`define FASC_B_EVT      0
`define FASC_B_VAL_SEL  1
`define FASC_B_EVEN     6
`define FASC_B_ODD      5

// reset values
`define FASC_RST_IDLE   8'hFF
`define FASC_RST_CODE   6'h3F
`define FASC_NO_MSG     6'h3F

// message framing
`define FASC_MSG_HEAD   8'hFE
`define FASC_MSG_LEN    4'hF
`define FASC_MSG_LAST   4'hE

// validation windows and hit thresholds
`define FASC_MASK_SHORT 10'h01F
`define FASC_MASK_LONG  10'h3FF
`define FASC_HITS_SHORT 4'h4
`define FASC_HITS_LONG  4'h8

// report period
`define FASC_REPORT_MS  1000
`define FASC_CLK_KHZ    125000

`endif

/* logic/fasc_pkg.sv */
// types for the framer auxiliary status and control bank
package fasc_pkg;

	// message transmitter states, one-hot
	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SEND = 2'b10
	} fasc_tx_state_type;

	// validation window lengths
	typedef logic [9:0] fasc_hist_mask_type;

endpackage : fasc_pkg

/* logic/fasc_bom_rx.sv */
// received bit-oriented message capture and validation
`timescale 1ns/10ps
`include "fasc_cfg.svh"
module fasc_msg_rx
	import fasc_pkg::*;
#(
	parameter int HIST = 10
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// data link bits
	input  wire logic       slot_i,
	input  wire logic       bit_i,
	input  wire logic       esf_i,
	input  wire logic       short_win_i,
	// declared message
	output logic            declare_o,
	output logic [5:0]      code_o
);
	logic [14:0]            sh_r;
	logic [3:0]             fill_r;
	logic [5:0]             hist_r [HIST-1];
	logic [5:0]             last_r;
	logic [HIST-1:0]        eq;
	logic [14:0]            sh_nxt;
	logic                   match;
	logic                   enough;
	logic [3:0]             hits;
	fasc_hist_mask_type     mask;

	assign sh_nxt = {sh_r[13:0], bit_i};
	assign match  = slot_i && esf_i && fill_r == `FASC_MSG_LAST
		&& sh_nxt[14:7] == `FASC_MSG_HEAD && !sh_nxt[0];
	assign eq[0]  = 1'b1;

	// --------------------------------------------------
	// compare new message against history
	// --------------------------------------------------
	genvar gi;
	for (gi = 1; gi < HIST; gi++) begin : g_eq
		assign eq[gi] = hist_r[gi-1] == sh_nxt[6:1];
	end

	assign mask   = short_win_i ? `FASC_MASK_SHORT : `FASC_MASK_LONG;
	assign hits   = 4'($countones(eq & mask));
	assign enough = short_win_i ? hits >= `FASC_HITS_SHORT : hits >= `FASC_HITS_LONG; // R13 R14
	assign code_o = last_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sh_r      <= '0;
			fill_r    <= '0;
			last_r    <= `FASC_NO_MSG;
			declare_o <= 1'b0;
			for (int i = 0; i < HIST-1; i++) hist_r[i] <= `FASC_NO_MSG;
		end else begin
			declare_o <= 1'b0;
			if (slot_i) begin
				sh_r   <= sh_nxt;
				fill_r <= match ? 4'h0 : (fill_r == `FASC_MSG_LAST ? fill_r : fill_r + 4'h1);
			end
			if (match) begin
				hist_r[0] <= sh_nxt[6:1];
				for (int i = 1; i < HIST-1; i++) hist_r[i] <= hist_r[i-1];
				if (enough && sh_nxt[6:1] != last_r) begin // R13 R14 R15
					last_r    <= sh_nxt[6:1];
					declare_o <= 1'b1;
				end
			end
		end
	end

	chk_declare_new: assert property (@(posedge clk_i) disable iff (rst_i) // R13
		declare_o |-> code_o != $past(last_r)) else $error("repeat message declared");
endmodule : fasc_msg_rx

/* logic/fasc_bank.sv */
// per-link auxiliary status and control register bank
//
// Chosen here: register access over Wishbone.
`timescale 1ns/10ps
`include "fasc_cfg.svh"
module fasc_bank
	import fasc_pkg::*;
#(
	parameter int          ADR_W      = 12,
	parameter int          HIST       = 10,
	parameter int unsigned REPORT_CYC = `FASC_REPORT_MS * `FASC_CLK_KHZ
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// wishbone slave
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [ADR_W-1:0]  adr_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic [31:0]       dat_i,
	output logic [31:0]            dat_o,
	output logic                   ack_o,
	// line status and mode
	input  wire logic              activate_code_present_i,
	input  wire logic              deactivate_code_present_i,
	input  wire logic              slip_event_i,
	input  wire logic              slip_full_i,
	input  wire logic              esf_mode_i,
	input  wire logic              dm_mode_i,
	input  wire logic              rx_in_sync_i,
	input  wire logic              rx_slave_mux_mode_i,
	// receive data path
	input  wire logic [7:0]        rx_data_i,
	output logic [7:0]             rx_data_o,
	// data link positions
	input  wire logic              dl_tx_slot_i,
	output logic                   dl_tx_bit_o,
	output logic                   dl_tx_msg_active_o,
	input  wire logic              dl_rx_slot_i,
	input  wire logic              dl_rx_bit_i,
	// performance report
	output logic                   perf_report_req_o,
	output logic [4:0]             perf_report_bits_o,
	// hdlc transmitters
	input  wire logic              frame_odd_i,
	output logic [2:0]             hdlc_tx_en_o,
	output logic [1:0]             hdlc_insert_o,
	output logic [4:0]             hdlc_tx2_channel_o,
	output logic [4:0]             hdlc_tx3_channel_o,
	// interrupt
	output logic                   irq_o
);
	localparam int CNT_W = $clog2(REPORT_CYC);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [1:0]        loop_en_r;
	logic              act_flag_r;
	logic              deact_flag_r;
	logic              act_prev_r;
	logic              deact_prev_r;
	logic              subst_en_r;
	logic              slip_en_r;
	logic              slip_dir_r;
	logic              slip_flag_r;
	logic [7:0]        idle_byte_r;
	logic [5:0]        rep_ctl_r;
	logic [5:0]        tx_code_r;
	logic              val_sel_r;
	logic              msg_en_r;
	logic              msg_flag_r;
	logic [5:0]        rx_code_r;
	logic [2:0]        tdlen_r;
	logic [6:0]        asg_r [2];
	logic              ack_r;
	logic [31:0]       dat_r;
	logic [CNT_W-1:0]  rep_cnt_r;
	logic [14:0]       tx_sh_r;
	logic [3:0]        tx_cnt_r;
	fasc_tx_state_type tx_state_r;
	fasc_tx_state_type tx_state_nxt;

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	logic [9:0] idx;
	logic       req;
	logic       wr;
	logic [7:0] wd;
	logic       h_len, h_lfl, h_cfg, h_sfl, h_idl, h_rep, h_txc;
	logic       h_mct, h_mfl, h_rxc, h_hen, h_as2, h_as3;
	logic [7:0] rd_byte;

	assign idx   = 10'(adr_i[ADR_W-1:2]);
	assign req   = cyc_i && stb_i;
	assign wr    = req && we_i && ack_r && sel_i[0];
	assign wd    = dat_i[7:0];
	assign h_len = idx == `FASC_IDX_LOOP_EN;
	assign h_lfl = idx == `FASC_IDX_LOOP_FLAG;
	assign h_cfg = idx == `FASC_IDX_ES_CFG;
	assign h_sfl = idx == `FASC_IDX_SLIP_FLAG;
	assign h_idl = idx == `FASC_IDX_IDLE_BYTE;
	assign h_rep = idx == `FASC_IDX_REPORT;
	assign h_txc = idx == `FASC_IDX_TX_CODE;
	assign h_mct = idx == `FASC_IDX_MSG_CTL;
	assign h_mfl = idx == `FASC_IDX_MSG_FLAG;
	assign h_rxc = idx == `FASC_IDX_RX_CODE;
	assign h_hen = idx == `FASC_IDX_HDLC_EN;
	assign h_as2 = idx == `FASC_IDX_ASSIGN2;
	assign h_as3 = idx == `FASC_IDX_ASSIGN3;

	assign rd_byte = ({8{h_len}} & {6'h00, loop_en_r})
		| ({8{h_lfl}} & {6'h00, act_flag_r, deact_flag_r})
		| ({8{h_cfg}} & {5'h00, subst_en_r, slip_dir_r, slip_en_r})
		| ({8{h_sfl}} & {7'h00, slip_flag_r})
		| ({8{h_idl}} & idle_byte_r)
		| ({8{h_rep}} & {2'h0, rep_ctl_r})
		| ({8{h_txc}} & {2'h0, tx_code_r})
		| ({8{h_mct}} & {6'h00, val_sel_r, msg_en_r})
		| ({8{h_mfl}} & {7'h00, msg_flag_r})
		| ({8{h_rxc}} & {2'h0, rx_code_r})
		| ({8{h_hen}} & {5'h00, tdlen_r})
		| ({8{h_as2}} & {1'b0, asg_r[0]})
		| ({8{h_as3}} & {1'b0, asg_r[1]});

	assign ack_o = ack_r;
	assign dat_o = dat_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= '0;
		end else begin
			ack_r <= req && !ack_r;
			dat_r <= {24'h000000, rd_byte};
		end
	end

	// ---------------------------------------------------------------
	// event flags, set wins over clear
	// ---------------------------------------------------------------
	logic act_tgl, deact_tgl;
	logic act_nxt, deact_nxt, slip_nxt, msg_nxt;
	logic declare;
	logic [5:0] declared_code;

	assign act_tgl   = activate_code_present_i != act_prev_r; // R2
	assign deact_tgl = deactivate_code_present_i != deact_prev_r; // R3
	assign act_nxt   = act_tgl || (act_flag_r && !(wr && h_lfl && wd[`FASC_B_ACT])); // R2 R4
	assign deact_nxt = deact_tgl
		|| (deact_flag_r && !(wr && h_lfl && wd[`FASC_B_DEACT])); // R3 R4
	assign slip_nxt  = slip_event_i
		|| (slip_flag_r && !(wr && h_sfl && wd[`FASC_B_EVT])); // R8 R4
	assign msg_nxt   = declare || (msg_flag_r && !(wr && h_mfl && wd[`FASC_B_EVT])); // R15 R4

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			act_prev_r   <= 1'b0;
			deact_prev_r <= 1'b0;
			act_flag_r   <= 1'b0;
			deact_flag_r <= 1'b0;
			slip_flag_r  <= 1'b0;
			msg_flag_r   <= 1'b0;
			slip_dir_r   <= 1'b0;
			rx_code_r    <= `FASC_RST_CODE;
		end else begin
			act_prev_r   <= activate_code_present_i;
			deact_prev_r <= deactivate_code_present_i;
			act_flag_r   <= act_nxt;
			deact_flag_r <= deact_nxt;
			slip_flag_r  <= slip_nxt;
			msg_flag_r   <= msg_nxt;
			if (slip_event_i)
				slip_dir_r <= slip_full_i; // R7
			if (declare)
				rx_code_r <= declared_code; // R15
		end
	end

	// ---------------------------------------------------------------
	// control registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			loop_en_r   <= '0;
			subst_en_r  <= 1'b0;
			slip_en_r   <= 1'b0;
			idle_byte_r <= `FASC_RST_IDLE; // R6
			rep_ctl_r   <= '0;
			tx_code_r   <= `FASC_RST_CODE;
			val_sel_r   <= 1'b0;
			msg_en_r    <= 1'b0;
			tdlen_r     <= '0;
		end else begin
			if (wr && h_len)
				loop_en_r <= wd[1:0];
			if (wr && h_cfg) begin
				subst_en_r <= wd[`FASC_B_SUBST];
				slip_en_r  <= wd[`FASC_B_EVT];
			end
			if (wr && h_idl)
				idle_byte_r <= wd; // R6
			if (wr && h_rep)
				rep_ctl_r <= wd[5:0];
			if (wr && h_txc)
				tx_code_r <= wd[5:0];
			if (wr && h_mct) begin
				val_sel_r <= wd[`FASC_B_VAL_SEL];
				msg_en_r  <= wd[`FASC_B_EVT];
			end
			if (wr && h_hen)
				tdlen_r <= wd[2:0];
		end
	end

	// ---------------------------------------------------------------
	// idle substitution on the receive path
	// ---------------------------------------------------------------
	logic subst;

	assign subst = rx_slave_mux_mode_i && !rx_in_sync_i && subst_en_r; // R5

	always_ff @(posedge clk_i) begin
		if (rst_i)
			rx_data_o <= '0;
		else
			rx_data_o <= subst ? idle_byte_r : rx_data_i; // R5
	end

	// ---------------------------------------------------------------
	// performance report timer
	// ---------------------------------------------------------------
	logic rep_on;
	logic rep_due;

	assign rep_on  = esf_mode_i && rep_ctl_r[0]; // R9
	assign rep_due = rep_cnt_r == CNT_W'(REPORT_CYC - 1);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rep_cnt_r          <= '0;
			perf_report_req_o  <= 1'b0;
			perf_report_bits_o <= '0;
		end else begin
			perf_report_req_o <= rep_on && rep_due; // R9
			if (!rep_on || rep_due)
				rep_cnt_r <= '0;
			else
				rep_cnt_r <= rep_cnt_r + 1'b1;
			if (rep_on && rep_due)
				perf_report_bits_o <= rep_ctl_r[5:1]; // R10
		end
	end

	// ---------------------------------------------------------------
	// transmitted bit-oriented message
	// ---------------------------------------------------------------
	logic        tx_valid;
	logic [14:0] tx_pat;
	logic        tx_load;

	assign tx_valid = esf_mode_i && tx_code_r != `FASC_RST_CODE; // R11
	assign tx_pat   = {`FASC_MSG_HEAD, tx_code_r[0], tx_code_r[1], tx_code_r[2],
		tx_code_r[3], tx_code_r[4], tx_code_r[5], 1'b0}; // R12
	assign tx_load  = dl_tx_slot_i && tx_valid
		&& (tx_state_r == TX_IDLE || tx_cnt_r == 4'h0);
	assign dl_tx_msg_active_o = tx_state_r == TX_SEND;

	always_comb begin
		tx_state_nxt = tx_state_r;
		unique case (tx_state_r)
			TX_IDLE: begin
				if (tx_load)
					tx_state_nxt = TX_SEND;
			end
			TX_SEND: begin
				if (dl_tx_slot_i && tx_cnt_r == 4'h0 && !tx_valid)
					tx_state_nxt = TX_IDLE;
			end
			default: tx_state_nxt = TX_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_state_r  <= TX_IDLE;
			tx_sh_r     <= '0;
			tx_cnt_r    <= '0;
			dl_tx_bit_o <= 1'b1;
		end else begin
			tx_state_r <= tx_state_nxt;
			if (tx_load) begin
				dl_tx_bit_o <= tx_pat[14]; // R12
				tx_sh_r     <= {tx_pat[13:0], 1'b0};
				tx_cnt_r    <= `FASC_MSG_LAST;
			end else if (dl_tx_slot_i && tx_state_r == TX_SEND && tx_cnt_r != 4'h0) begin
				dl_tx_bit_o <= tx_sh_r[14];
				tx_sh_r     <= {tx_sh_r[13:0], 1'b0};
				tx_cnt_r    <= tx_cnt_r - 4'h1;
			end else if (tx_state_nxt == TX_IDLE) begin
				dl_tx_bit_o <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// received bit-oriented message
	// ---------------------------------------------------------------
	fasc_msg_rx #(
		.HIST        (HIST)
	) u_msg_rx (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.slot_i      (dl_rx_slot_i),
		.bit_i       (dl_rx_bit_i),
		.esf_i       (esf_mode_i),
		.short_win_i (val_sel_r),
		.declare_o   (declare),
		.code_o      (declared_code)
	);

	// ---------------------------------------------------------------
	// hdlc transmitter enables and slot assignment
	// ---------------------------------------------------------------
	genvar gk;
	for (gk = 0; gk < 2; gk++) begin : g_asg
		logic [9:0] a_idx;
		logic       a_ins;

		assign a_idx = gk == 0 ? `FASC_IDX_ASSIGN2 : `FASC_IDX_ASSIGN3;
		assign a_ins = tdlen_r[gk+1] && (frame_odd_i ? asg_r[gk][`FASC_B_ODD]
			: asg_r[gk][`FASC_B_EVEN]); // R17 R19 R20

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				asg_r[gk]         <= '0;
				hdlc_insert_o[gk] <= 1'b0;
			end else begin
				if (wr && idx == a_idx)
					asg_r[gk] <= wd[6:0];
				hdlc_insert_o[gk] <= a_ins; // R19 R20
			end
		end
	end

	// channel is only meaningful while insert is asserted
	assign hdlc_tx2_channel_o = asg_r[0][4:0]; // R21
	assign hdlc_tx3_channel_o = asg_r[1][4:0]; // R21

	always_ff @(posedge clk_i) begin
		if (rst_i)
			hdlc_tx_en_o <= '0;
		else
			hdlc_tx_en_o <= {tdlen_r[2:1], tdlen_r[0] && (esf_mode_i || dm_mode_i)}; // R17 R18
	end

	// ---------------------------------------------------------------
	// interrupt
	// ---------------------------------------------------------------
	assign irq_o = (act_flag_r && loop_en_r[`FASC_B_ACT])
		|| (deact_flag_r && loop_en_r[`FASC_B_DEACT]) // R1
		|| (slip_flag_r && slip_en_r) // R8
		|| (msg_flag_r && msg_en_r); // R16 R22

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_deact_irq: assert property (deact_flag_r && loop_en_r[`FASC_B_DEACT] |-> irq_o) // R1
		else $error("deactivate flag not interrupting");
	chk_act_toggle: assert property ($changed(activate_code_present_i) // R2
		|=> act_flag_r) else $error("activate toggle lost");
	chk_deact_toggle: assert property (deactivate_code_present_i != deact_prev_r // R3
		|=> deact_flag_r) else $error("deactivate toggle lost");
	chk_w1c_clear: assert property (wr && h_sfl && wd[`FASC_B_EVT] && !slip_event_i // R4
		|=> !slip_flag_r) else $error("slip flag not cleared");
	chk_idle_subst: assert property (subst |=> rx_data_o == $past(idle_byte_r)) // R5
		else $error("idle byte not substituted");
	chk_slip_dir: assert property (slip_event_i |=> slip_dir_r == $past(slip_full_i) // R7
		&& slip_flag_r) else $error("slip cause wrong");
	chk_slip_irq: assert property (slip_flag_r && !slip_en_r && !msg_flag_r // R8
		&& !act_flag_r && !deact_flag_r |-> !irq_o) else $error("stray interrupt");
	chk_report_bits: assert property (perf_report_req_o |-> !$past(perf_report_req_o) // R10
		&& perf_report_bits_o == $past(rep_ctl_r[5:1])) else $error("bad report");
	chk_msg_start: assert property (tx_state_r == TX_IDLE && tx_load // R11
		|=> dl_tx_bit_o ##0 dl_tx_msg_active_o) else $error("message not started");
	chk_msg_flag: assert property (declare |=> msg_flag_r && rx_code_r == $past(declared_code))
		else $error("declared message not loaded"); // R15
	chk_msg_irq: assert property (msg_flag_r && msg_en_r |-> irq_o) // R16
		else $error("message flag not interrupting");
	chk_hdlc_one: assert property (!esf_mode_i && !dm_mode_i |=> !hdlc_tx_en_o[0]) // R18
		else $error("transmitter one enabled outside ESF/DM");

	cov_msg_declared: cover property (declare ##1 irq_o);
	cov_slip_clear: cover property (slip_flag_r ##1 wr && h_sfl ##1 !slip_flag_r);
	cov_msg_sent: cover property (tx_state_r == TX_SEND ##1 tx_state_r == TX_IDLE);
endmodule : fasc_bank

/* verification/fasc_line_model.sv */
// far-end line model sending bit-oriented messages on the receive data link
`timescale 1ns/10ps
module fasc_line_model (
	// clock
	input  wire logic clk_i,
	// receive data link
	output logic      slot_o,
	output logic      bit_o
);
	initial begin
		slot_o = 1'b0;
		bit_o  = 1'b0;
	end

	// header first, then code bit 0 up to 5, then a closing zero
	task automatic send(input logic [5:0] code, input int n);
		logic [14:0] m;
		m = {8'hFE, code[0], code[1], code[2], code[3], code[4], code[5], 1'b0};
		repeat (n) begin
			for (int i = 14; i >= 0; i--) begin
				@(posedge clk_i);
				slot_o <= 1'b1;
				bit_o  <= m[i];
				@(posedge clk_i);
				slot_o <= 1'b0;
				bit_o  <= ~m[i];
			end
		end
	endtask : send
endmodule : fasc_line_model

/* verification/tb_fasc_bank.sv */
// self-checking bench for the auxiliary status and control bank
`timescale 1ns/10ps
`include "fasc_cfg.svh"
module tb_fasc_bank;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
	logic [11:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o;
	logic activate_code_present_i, deactivate_code_present_i, slip_event_i, slip_full_i;
	logic esf_mode_i, dm_mode_i, rx_in_sync_i, rx_slave_mux_mode_i, frame_odd_i;
	logic [7:0] rx_data_i, rx_data_o, b;
	logic dl_tx_slot_i, dl_tx_bit_o, dl_tx_msg_active_o, dl_rx_slot_i, dl_rx_bit_i;
	logic perf_report_req_o;
	logic [4:0] perf_report_bits_o, hdlc_tx2_channel_o, hdlc_tx3_channel_o, r, ch;
	logic [2:0] hdlc_tx_en_o;
	logic [1:0] hdlc_insert_o;
	logic [5:0] c, c3;
	logic [14:0] m;
	logic [7:0] exp_q[$];
	int failures, n_checks, t;

	fasc_bank #(.REPORT_CYC(50)) dut_u (.*);
	fasc_line_model line_u (.clk_i(clk_i), .slot_o(dl_rx_slot_i), .bit_o(dl_rx_bit_i));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic finish_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test

	// one classic cycle, entered just after a rising edge
	task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= {a, 2'b00};
		dat_i <= {24'h000000, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		@(posedge clk_i);
	endtask : bus

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		bus(a, 1'b1, d);
	endtask : wr

	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus(a, 1'b0, 8'h00);
	endtask : rd

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick

	// read data watcher
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0 && cyc_i === 1'b1) begin
			if (exp_q.size() == 0) chk("unexpected read", 32'h0, 32'h1);
			else chk("read data", {24'h000000, exp_q.pop_front()}, dat_o);
		end
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		finish_test;
	end

	initial begin
		{rst_i, rx_in_sync_i} = 2'b11;
		{cyc_i, stb_i, we_i, activate_code_present_i, deactivate_code_present_i} = '0;
		{slip_event_i, slip_full_i, esf_mode_i, dm_mode_i, rx_slave_mux_mode_i} = '0;
		{frame_odd_i, dl_tx_slot_i, adr_i, dat_i, rx_data_i} = '0;
		sel_i = 4'hF;
		failures = 0;
		n_checks = 0;
		void'($urandom(59695));
		tick(3);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// -----------------------------------------------
		// reset values and idle substitution
		// -----------------------------------------------
		rd(`FASC_IDX_IDLE_BYTE, 8'hFF);
		rd(`FASC_IDX_TX_CODE, 8'h3F);
		rd(`FASC_IDX_RX_CODE, 8'h3F);
		rd(`FASC_IDX_LOOP_FLAG, 8'h00);
		rd(10'h085, 8'h00);
		b = 8'($urandom);
		wr(`FASC_IDX_IDLE_BYTE, b);
		rd(`FASC_IDX_IDLE_BYTE, b);
		wr(`FASC_IDX_ES_CFG, 8'h04);
		rx_slave_mux_mode_i <= 1'b1;
		rx_in_sync_i <= 1'b0;
		rx_data_i <= ~b;
		tick(2);
		chk("substituted byte", b, rx_data_o);
		rx_in_sync_i <= 1'b1;
		tick(2);
		chk("passed byte", {24'h000000, ~b}, rx_data_o);
		// -----------------------------------------------
		// loop-code flags, slip flag, interrupt
		// -----------------------------------------------
		activate_code_present_i <= 1'b1;
		tick(2);
		rd(`FASC_IDX_LOOP_FLAG, 8'h02);
		wr(`FASC_IDX_LOOP_EN, 8'h01);
		chk("irq masked", 0, irq_o);
		deactivate_code_present_i <= 1'b1;
		tick(2);
		chk("irq deactivate", 1, irq_o);
		wr(`FASC_IDX_LOOP_FLAG, 8'h00);
		rd(`FASC_IDX_LOOP_FLAG, 8'h03);
		wr(`FASC_IDX_LOOP_FLAG, 8'h01);
		chk("irq cleared", 0, irq_o);
		deactivate_code_present_i <= 1'b0;
		tick(2);
		rd(`FASC_IDX_LOOP_FLAG, 8'h03);
		wr(`FASC_IDX_LOOP_FLAG, 8'h03);
		rd(`FASC_IDX_LOOP_FLAG, 8'h00);
		for (int k = 1; k >= 0; k--) begin
			slip_event_i <= 1'b1;
			slip_full_i <= k[0];
			@(posedge clk_i);
			slip_event_i <= 1'b0;
			tick(1);
			rd(`FASC_IDX_SLIP_FLAG, 8'h01);
			rd(`FASC_IDX_ES_CFG, {5'h00, 1'b1, k[0], !k[0]});
			wr(`FASC_IDX_ES_CFG, 8'h05);
			chk("irq slip", 1, irq_o);
			wr(`FASC_IDX_SLIP_FLAG, 8'h01);
			chk("irq slip clear", 0, irq_o);
		end
		// -----------------------------------------------
		// bit-oriented messages
		// -----------------------------------------------
		esf_mode_i <= 1'b1;
		c = 6'($urandom % 63);
		wr(`FASC_IDX_TX_CODE, {2'b00, c});
		m = {8'hFE, c[0], c[1], c[2], c[3], c[4], c[5], 1'b0};
		for (int i = 14; i >= -1; i--) begin
			if (i < 0) wr(`FASC_IDX_TX_CODE, 8'h3F);
			dl_tx_slot_i <= 1'b1;
			@(posedge clk_i);
			dl_tx_slot_i <= 1'b0;
			@(posedge clk_i);
			if (i >= 0) chk("message bit", m[i], dl_tx_bit_o);
			else chk("message idle", 0, dl_tx_msg_active_o);
		end
		wr(`FASC_IDX_MSG_CTL, 8'h03);
		c = 6'($urandom % 31);
		c3 = c + 6'h20;
		line_u.send(c, 5);
		tick(3);
		rd(`FASC_IDX_MSG_FLAG, 8'h01);
		rd(`FASC_IDX_RX_CODE, {2'b00, c[0], c[1], c[2], c[3], c[4], c[5]});
		chk("irq message", 1, irq_o);
		wr(`FASC_IDX_MSG_FLAG, 8'h01);
		wr(`FASC_IDX_MSG_CTL, 8'h00);
		line_u.send(c3, 7);
		tick(3);
		rd(`FASC_IDX_MSG_FLAG, 8'h00);
		line_u.send(c3, 1);
		tick(3);
		rd(`FASC_IDX_MSG_FLAG, 8'h01);
		rd(`FASC_IDX_RX_CODE, {2'b00, c3[0], c3[1], c3[2], c3[3], c3[4], c3[5]});
		chk("irq message masked", 0, irq_o);
		// -----------------------------------------------
		// performance report and hdlc transmitters
		// -----------------------------------------------
		r = 5'($urandom);
		wr(`FASC_IDX_REPORT, {2'b00, r, 1'b1});
		t = 0;
		while (perf_report_req_o !== 1'b1 && t < 200) begin
			@(posedge clk_i);
			t++;
		end
		chk("report pulse", 1, perf_report_req_o);
		chk("report bits", r, perf_report_bits_o);
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (perf_report_req_o !== 1'b1 && t < 200);
		chk("report period", 50, t);
		esf_mode_i <= 1'b0;
		wr(`FASC_IDX_HDLC_EN, 8'h07);
		tick(1);
		chk("hdlc enables", 3'b110, hdlc_tx_en_o);
		dm_mode_i <= 1'b1;
		tick(2);
		chk("hdlc enables dm", 3'b111, hdlc_tx_en_o);
		ch = 5'($urandom % 24);
		wr(`FASC_IDX_ASSIGN2, {3'b010, ch});
		wr(`FASC_IDX_ASSIGN3, {3'b001, 5'd23 - ch});
		chk("even insert", 2'b01, hdlc_insert_o);
		chk("channel two", ch, hdlc_tx2_channel_o);
		chk("channel three", 5'd23 - ch, hdlc_tx3_channel_o);
		frame_odd_i <= 1'b1;
		tick(2);
		chk("odd insert", 2'b10, hdlc_insert_o);
		wr(`FASC_IDX_HDLC_EN, 8'h00);
		tick(1);
		chk("hdlc disabled", 3'b000, hdlc_tx_en_o);
		chk("insert disabled", 2'b00, hdlc_insert_o);
		finish_test;
	end
endmodule : tb_fasc_bank
